// File: common/bml_pkg.sv
// Package: boot mode loader constants and types
package bml_pkg;
    // ****************************************************************
    // Boot modes
    // ****************************************************************
    typedef enum logic [2:0] {
        bml_mode_none,
        bml_mode_host,
        bml_mode_link,
        bml_mode_eprom,
        bml_mode_reserved
    } bml_mode_type;

    // ****************************************************************
    // Register offsets (plain register port, word index)
    // ****************************************************************
    localparam logic [3:0] ADDR_DMA_CTRL_CH10 = 4'h0;
    localparam logic [3:0] ADDR_DMA_CTRL_CH6 = 4'h1;
    localparam logic [3:0] ADDR_INT_INDEX = 4'h2;
    localparam logic [3:0] ADDR_INT_COUNT = 4'h3;
    localparam logic [3:0] ADDR_SECOND_MODE = 4'h4;
    localparam logic [3:0] ADDR_SYS_CONFIG = 4'h5;
    localparam logic [3:0] ADDR_INT_MASK = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_INSTR_LO = 4'h8;
    localparam logic [3:0] ADDR_INSTR_HI = 4'h9;
    localparam logic [3:0] ADDR_WAIT = 4'hA;
    localparam logic [3:0] ADDR_EXT_BUF0 = 4'hB;

    // ****************************************************************
    // Reset values and completion mask value
    // ****************************************************************
    localparam logic [31:0] DMA_CH10_HOST_RST = 32'h0000_04A1;
    localparam logic [31:0] DMA_CH10_LINK_RST = 32'h0010_0000;
    localparam logic [31:0] DMA_CH6_LINK_RST = 32'h0000_00A0;
    localparam logic [31:0] DMA_DEFAULT_RST = 32'h0000_0000;
    localparam logic [31:0] INT_INDEX_RST = 32'h0004_0000;
    localparam logic [31:0] INT_COUNT_RST = 32'h0000_0100;
    localparam logic [31:0] PC_HOST_LINK = 32'h0004_0004;
    localparam logic [31:0] PC_NO_BOOT = 32'h0080_0004;
    localparam logic [31:0] WAIT_RST = 32'h0000_0006;
    localparam logic [31:0] INT_MASK_DMA = 32'h0000_0001;

    // ****************************************************************
    // Field positions and link nibbles per word
    // ****************************************************************
    localparam int DMA_EN_BIT = 0;
    localparam int DMA_PACKING_MODE_LSB = 6;
    localparam int BUS_LOCK_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_IRQ_BIT = 1;
    localparam int STAT_GRANT_BIT = 2;
    localparam int STAT_MODE_LSB = 4;
    localparam int NIBBLES = 12;
endpackage : bml_pkg

// File: hdl/bml_loader.sv
// Boot mode selection and boot DMA loader for host and link boot
// Behaviour
// - Mode inputs 0,0 with boot memory select high choose host boot.
// - Host boot: slave mode, idle, program counter 0x40004, wait for host.
// - Host boot DMA parameters reset as for link boot; no transfer starts alone.
// - Host boot ch10 control: enabled, instruction type, 16-to-48, LSW first.
// - Device returns grant and acknowledge (chip select high) or ready (low); host writes only after that.
// - Boot DMA stops by itself after 256 instructions loaded.
// - Bus lock bit set locks host out; clearing lets host write again.
// - Packing mode 00 makes the slave accept instruction words unpacked.
// - Wait states, 6 at reset, apply only as bus master, not as slave.
// - Link boot packs 4-bit link nibbles into 48-bit instructions, channel 6.
// - Eprom low, link and boot memory select high choose link boot.
// - Sender supplies link clock; data captured on its falling edges.
// - Link boot: ch6 control 0x00A0, ch10 control 0x100000.
// - Link boot overrides link controls so buffer 4 takes 48-bit data.
// - No-boot fetches from 0x800004; DMA registers take default values.
// - After link boot the mask still allows DMA interrupts.
// - All inputs low choose no-boot; other odd combinations are reserved.
// - Reset internal index 0x40000 and word count 0x100.
module bml_loader #(
    parameter int BOOT_WORDS = 256
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Boot mode straps
    input wire logic eprom_boot_select,
    input wire logic link_boot_select,
    input wire logic boot_memory_select,
    // Host parallel port
    input wire logic host_bus_request_n,
    input wire logic host_chip_select_n,
    output logic host_bus_grant_n,
    output logic host_ack,
    output logic host_ready,
    // Link port
    input wire logic link_clock,
    input wire logic [3:0] link_data,
    output logic link_ack,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Instruction write into internal memory
    output logic instr_valid,
    output logic [47:0] instr_word,
    output logic [31:0] instr_addr,
    // Core state
    output logic [31:0] program_counter,
    output logic core_idle,
    output logic dma_irq
);
    // ****************************************************************
    // Checks and strap, host and link pin synchronisers
    // ****************************************************************
    if (BOOT_WORDS < 1 || BOOT_WORDS > 65535) begin : g_bad_words
        $error("BOOT_WORDS out of range");
    end

    logic [2:0] strap_s1_reg, strap_s2_reg;
    logic [1:0] hreq_s1_reg, hreq_s2_reg;
    logic [4:0] link_s1_reg, link_s2_reg;
    logic link_clk_prev_reg;

    // Two stages for every asynchronous pin before use
    always_ff @(posedge clock) begin
        strap_s1_reg <= {eprom_boot_select, link_boot_select,
                         boot_memory_select};
        strap_s2_reg <= strap_s1_reg;
        hreq_s1_reg <= {host_bus_request_n, host_chip_select_n};
        hreq_s2_reg <= hreq_s1_reg;
        link_s1_reg <= {link_clock, link_data};
        link_s2_reg <= link_s1_reg;
    end

    // ****************************************************************
    // Boot state
    // ****************************************************************
    bml_pkg::bml_mode_type mode_reg, mode_next;
    logic [31:0] dma_ch10_reg, dma_ch10_next;
    logic [31:0] dma_ch6_reg, dma_ch6_next;
    logic [31:0] int_index_reg, int_index_next;
    logic [31:0] int_count_reg, int_count_next;
    logic [31:0] second_mode_reg, second_mode_next;
    logic [31:0] sys_config_reg, sys_config_next;
    logic [31:0] int_mask_reg, int_mask_next;
    logic [31:0] wait_reg, wait_next;
    logic [31:0] pc_reg, pc_next;
    logic [47:0] pack_reg, pack_next;
    logic [3:0] piece_reg, piece_next;
    logic done_reg, done_next;
    logic irq_reg, irq_next;
    logic irqm_reg, irqm_next;
    logic idle_reg, idle_next;
    logic grant_reg, grant_next;
    logic ack_reg, ack_next;
    logic rdy_reg, rdy_next;
    logic lack_reg, lack_next;
    logic ivalid_reg, ivalid_next;
    logic [47:0] iword_reg, iword_next;
    logic [31:0] iaddr_reg, iaddr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic link_fall;
    logic [1:0] dma_packing_mode;
    logic host_wr;

    assign link_fall = link_clk_prev_reg && !link_s2_reg[4];
    assign dma_packing_mode = dma_ch10_reg[bml_pkg::DMA_PACKING_MODE_LSB +: 2];
    // Host write to buffer zero, refused while bus locked
    assign host_wr = reg_write && reg_addr == bml_pkg::ADDR_EXT_BUF0
                     && grant_reg
                     && !second_mode_reg[bml_pkg::BUS_LOCK_BIT];

    // Next-state logic for decoding, packing and registers
    always_comb begin
        logic dma_run;
        logic take;
        logic [47:0] word;
        dma_run = 1'b0;
        take = 1'b0;
        word = pack_reg;
        mode_next = mode_reg;
        dma_ch10_next = dma_ch10_reg;
        dma_ch6_next = dma_ch6_reg;
        int_index_next = int_index_reg;
        int_count_next = int_count_reg;
        second_mode_next = second_mode_reg;
        sys_config_next = sys_config_reg;
        int_mask_next = int_mask_reg;
        wait_next = wait_reg;
        pc_next = pc_reg;
        pack_next = pack_reg;
        piece_next = piece_reg;
        done_next = done_reg;
        irq_next = irq_reg;
        idle_next = idle_reg;
        grant_next = grant_reg;
        ack_next = 1'b0;
        rdy_next = 1'b0;
        lack_next = 1'b0;
        ivalid_next = 1'b0;
        iword_next = iword_reg;
        iaddr_next = iaddr_reg;
        rdata_next = 32'h0000_0000;
        if (rst) begin
            // Strap decode while reset is held
            unique casez (strap_s2_reg)
                3'b000: mode_next = bml_pkg::bml_mode_none;
                3'b001: mode_next = bml_pkg::bml_mode_host;
                3'b011: mode_next = bml_pkg::bml_mode_link;
                3'b10?: mode_next = bml_pkg::bml_mode_eprom;
                default: mode_next = bml_pkg::bml_mode_reserved;
            endcase
            dma_ch10_next = bml_pkg::DMA_DEFAULT_RST;
            dma_ch6_next = bml_pkg::DMA_DEFAULT_RST;
            int_index_next = bml_pkg::DMA_DEFAULT_RST;
            int_count_next = bml_pkg::DMA_DEFAULT_RST;
            pc_next = bml_pkg::PC_NO_BOOT;
            idle_next = 1'b0;
            if (mode_next == bml_pkg::bml_mode_host ||
                mode_next == bml_pkg::bml_mode_link) begin
                int_index_next = bml_pkg::INT_INDEX_RST;
                int_count_next = 32'(BOOT_WORDS);
                pc_next = bml_pkg::PC_HOST_LINK;
                idle_next = 1'b1;
            end
            if (mode_next == bml_pkg::bml_mode_host) begin
                dma_ch10_next = bml_pkg::DMA_CH10_HOST_RST;
            end
            if (mode_next == bml_pkg::bml_mode_link) begin
                dma_ch10_next = bml_pkg::DMA_CH10_LINK_RST;
                dma_ch6_next = bml_pkg::DMA_CH6_LINK_RST;
            end
            second_mode_next = 32'h0000_0000;
            sys_config_next = 32'h0000_0000;
            int_mask_next = 32'h0000_0000;
            wait_next = bml_pkg::WAIT_RST;
            pack_next = 48'h0000_0000_0000;
            piece_next = 4'h0;
            done_next = 1'b0;
            irq_next = 1'b0;
            grant_next = 1'b0;
            iword_next = 48'h0000_0000_0000;
            iaddr_next = 32'h0000_0000;
        end else begin
            dma_run = !done_reg && int_count_reg != 32'h0000_0000;
            // Grant host port in slave mode; no wait states here
            grant_next = mode_reg == bml_pkg::bml_mode_host
                         && !hreq_s2_reg[1];
            ack_next = grant_next && hreq_s2_reg[0];
            rdy_next = grant_next && !hreq_s2_reg[0];
            if (mode_reg == bml_pkg::bml_mode_host && host_wr && dma_run
                && dma_ch10_reg[bml_pkg::DMA_EN_BIT]) begin
                if (dma_packing_mode == 2'b00) begin
                    // Unpacked: each write is a whole word
                    word = {16'h0000, reg_wdata};
                    take = 1'b1;
                end else begin
                    // 16-bit pieces, least significant first
                    word = {reg_wdata[15:0], pack_reg[47:16]};
                    pack_next = word;
                    piece_next = piece_reg + 4'h1;
                    if (piece_reg == 4'h2) begin
                        take = 1'b1;
                    end
                end
            end
            if (mode_reg == bml_pkg::bml_mode_link && link_fall
                && dma_run) begin
                // Channel 6 via buffer 4, forced 48-bit receive
                word = {pack_reg[43:0], link_s2_reg[3:0]};
                pack_next = word;
                piece_next = piece_reg + 4'h1;
                lack_next = 1'b1;
                if (piece_reg == 4'(bml_pkg::NIBBLES - 1)) begin
                    take = 1'b1;
                end
            end
            if (take) begin
                piece_next = 4'h0;
                ivalid_next = 1'b1;
                iword_next = word;
                iaddr_next = int_index_reg;
                int_index_next = int_index_reg + 32'h0000_0001;
                int_count_next = int_count_reg - 32'h0000_0001;
                if (int_count_reg == 32'h0000_0001) begin
                    done_next = 1'b1;
                    irq_next = 1'b1;
                    idle_next = 1'b0;
                    int_mask_next = bml_pkg::INT_MASK_DMA;
                end
            end
            // Software register writes
            if (reg_write) begin
                unique case (reg_addr)
                    bml_pkg::ADDR_DMA_CTRL_CH10: dma_ch10_next = reg_wdata;
                    bml_pkg::ADDR_DMA_CTRL_CH6: dma_ch6_next = reg_wdata;
                    bml_pkg::ADDR_SECOND_MODE: second_mode_next = reg_wdata;
                    bml_pkg::ADDR_SYS_CONFIG: sys_config_next = reg_wdata;
                    bml_pkg::ADDR_INT_MASK: int_mask_next = reg_wdata;
                    bml_pkg::ADDR_WAIT: wait_next = reg_wdata;
                    bml_pkg::ADDR_STATUS: begin
                        // Completion event wins over the clear
                        irq_next = irq_next && !take && reg_wdata[1]
                                   ? irq_next : (take && done_next);
                    end
                    default: begin
                    end
                endcase
            end
            // Read data one cycle after the strobe
            if (reg_read) begin
                unique case (reg_addr)
                    bml_pkg::ADDR_DMA_CTRL_CH10: rdata_next = dma_ch10_reg;
                    bml_pkg::ADDR_DMA_CTRL_CH6: rdata_next = dma_ch6_reg;
                    bml_pkg::ADDR_INT_INDEX: rdata_next = int_index_reg;
                    bml_pkg::ADDR_INT_COUNT: rdata_next = int_count_reg;
                    bml_pkg::ADDR_SECOND_MODE: rdata_next = second_mode_reg;
                    bml_pkg::ADDR_SYS_CONFIG: rdata_next = sys_config_reg;
                    bml_pkg::ADDR_INT_MASK: rdata_next = int_mask_reg;
                    bml_pkg::ADDR_STATUS: begin
                        rdata_next[bml_pkg::STAT_DONE_BIT] = done_reg;
                        rdata_next[bml_pkg::STAT_IRQ_BIT] = irq_reg;
                        rdata_next[bml_pkg::STAT_GRANT_BIT] = grant_reg;
                        rdata_next[bml_pkg::STAT_MODE_LSB +: 3] = mode_reg;
                    end
                    bml_pkg::ADDR_INSTR_LO: rdata_next = iword_reg[31:0];
                    bml_pkg::ADDR_INSTR_HI:
                        rdata_next = {16'h0000, iword_reg[47:32]};
                    bml_pkg::ADDR_WAIT: rdata_next = wait_reg;
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
        irqm_next = irq_next && int_mask_next[0];
    end

    // Registers only
    always_ff @(posedge clock) begin
        link_clk_prev_reg <= link_s2_reg[4];
        mode_reg <= mode_next;
        dma_ch10_reg <= dma_ch10_next;
        dma_ch6_reg <= dma_ch6_next;
        int_index_reg <= int_index_next;
        int_count_reg <= int_count_next;
        second_mode_reg <= second_mode_next;
        sys_config_reg <= sys_config_next;
        int_mask_reg <= int_mask_next;
        wait_reg <= wait_next;
        pc_reg <= pc_next;
        pack_reg <= pack_next;
        piece_reg <= piece_next;
        done_reg <= done_next;
        irq_reg <= irq_next;
        irqm_reg <= irqm_next;
        idle_reg <= idle_next;
        grant_reg <= grant_next;
        ack_reg <= ack_next;
        rdy_reg <= rdy_next;
        lack_reg <= lack_next;
        ivalid_reg <= ivalid_next;
        iword_reg <= iword_next;
        iaddr_reg <= iaddr_next;
        rdata_reg <= rdata_next;
    end

    // ****************************************************************
    // Outputs straight from flip-flops
    // ****************************************************************
    assign host_bus_grant_n = !grant_reg;
    assign host_ack = ack_reg;
    assign host_ready = rdy_reg;
    assign link_ack = lack_reg;
    assign reg_rdata = rdata_reg;
    assign instr_valid = ivalid_reg;
    assign instr_word = iword_reg;
    assign instr_addr = iaddr_reg;
    assign program_counter = pc_reg;
    assign core_idle = idle_reg;
    assign dma_irq = irqm_reg;
endmodule : bml_loader

// File: testbench/bml_loader_properties.sv
// Checker: port-level properties of the boot mode loader
module bml_loader_properties #(
    parameter int BOOT_WORDS = 256
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Straps and host port
    input wire logic eprom_boot_select,
    input wire logic link_boot_select,
    input wire logic boot_memory_select,
    input wire logic host_bus_request_n,
    input wire logic host_chip_select_n,
    input wire logic host_bus_grant_n,
    input wire logic host_ack,
    input wire logic host_ready,
    // Loader results
    input wire logic instr_valid,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] program_counter,
    input wire logic core_idle,
    input wire logic dma_irq
);
    // ****************************************************************
    // Helper state
    // ****************************************************************
    logic [2:0] strap_reg;
    logic [2:0] strap_next;
    logic [31:0] word_reg;
    logic [31:0] word_next;
    logic is_host;
    logic is_link;
    logic is_none;

    // Straps frozen in reset, loads counted
    always_comb begin
        strap_next = rst ? {eprom_boot_select, link_boot_select,
                            boot_memory_select} : strap_reg;
        word_next = rst ? 32'h0 : word_reg + {31'h0, instr_valid};
    end

    always_ff @(posedge clock) begin
        strap_reg <= strap_next;
        word_reg <= word_next;
    end

    assign is_host = (strap_reg == 3'h1);
    assign is_link = (strap_reg == 3'h3);
    assign is_none = (strap_reg == 3'h0);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_HOST_GRANT: assert property (
        is_host && $fell(host_bus_request_n) |->
            ##[1:6] (!host_bus_grant_n || host_bus_request_n))
        else $error("grant did not follow bus request");
    AST_GRANT_ANSWER: assert property (
        $fell(host_bus_grant_n) |->
            ##[0:1] (host_chip_select_n ? host_ack : host_ready))
        else $error("grant came without ack or ready");
    AST_GRANT_NEEDS_REQ: assert property (
        host_bus_request_n [*4] |-> host_bus_grant_n)
        else $error("grant held without request");
    AST_GRANT_HOST_ONLY: assert property (
        !is_host |-> host_bus_grant_n)
        else $error("grant outside host boot");
    AST_START_PC: assert property (
        $fell(rst) && (is_host || is_link || is_none) |->
            program_counter == (is_none ? bml_pkg::PC_NO_BOOT
                                        : bml_pkg::PC_HOST_LINK))
        else $error("wrong start address");
    AST_START_IDLE: assert property (
        $fell(rst) && (is_host || is_link) |-> ##[0:2] core_idle)
        else $error("core not idle in boot");
    AST_INSTR_ADDR: assert property (
        instr_valid |-> instr_addr == bml_pkg::INT_INDEX_RST + word_reg)
        else $error("instruction address off");
    AST_BOOT_STOP: assert property (
        word_reg == BOOT_WORDS |-> !instr_valid)
        else $error("load past boot count");
    AST_DONE_IRQ: assert property (
        instr_valid && word_reg == BOOT_WORDS - 1 |->
            ##[1:2] (dma_irq && !core_idle))
        else $error("no completion interrupt");
    AST_NO_LOAD: assert property (
        !(is_host || is_link) |-> !instr_valid)
        else $error("load outside host or link boot");
endmodule : bml_loader_properties

bind bml_loader bml_loader_properties #(.BOOT_WORDS(BOOT_WORDS)) chk_u (
    .clock(clock), .rst(rst), .eprom_boot_select(eprom_boot_select),
    .link_boot_select(link_boot_select),
    .boot_memory_select(boot_memory_select),
    .host_bus_request_n(host_bus_request_n),
    .host_chip_select_n(host_chip_select_n),
    .host_bus_grant_n(host_bus_grant_n), .host_ack(host_ack),
    .host_ready(host_ready), .instr_valid(instr_valid),
    .instr_addr(instr_addr), .program_counter(program_counter),
    .core_idle(core_idle), .dma_irq(dma_irq));

// File: testbench/bml_link_sender.sv
// Partner: link-port device that clocks boot nibbles into the loader
module bml_link_sender (
    // Link port
    output logic link_clock,
    output logic [3:0] link_data,
    input wire logic link_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock rests high between frames; ack is never looked at
    initial begin
        link_clock = 1'b1;
        link_data = 4'h0;
    end

    // One 48-bit word, 160 ns per nibble, own phase
    task automatic send_word(input logic [47:0] w);
        #7;
        for (int i = 11; i >= 0; i--) begin
            link_data = w[4 * i +: 4];
            #80 link_clock = 1'b0;
            #80 link_clock = 1'b1;
        end
        // Stale data would hide a late capture
        link_data = ~link_data;
    endtask : send_word
endmodule : bml_link_sender

// File: testbench/bml_loader_bench.sv
// Testbench: host, link and no-boot runs of the boot mode loader
module bml_loader_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic eprom_boot_select = 1'b0;
    logic link_boot_select = 1'b0;
    logic boot_memory_select = 1'b1;
    logic host_bus_request_n = 1'b1;
    logic host_chip_select_n = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic host_bus_grant_n, host_ack, host_ready, link_ack, link_clock;
    logic instr_valid, core_idle, dma_irq;
    logic [3:0] link_data;
    logic [31:0] reg_rdata, instr_addr, program_counter, rd;
    logic [47:0] instr_word, w;
    logic [47:0] exp_q[$];
    logic [47:0] got_q[$];
    logic [31:0] adr_q[$];
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_ack = 0;

    always #10 clock = ~clock;

    bml_loader #(.BOOT_WORDS(WORDS)) dut_u (
        .clock(clock), .rst(rst), .eprom_boot_select(eprom_boot_select),
        .link_boot_select(link_boot_select),
        .boot_memory_select(boot_memory_select),
        .host_bus_request_n(host_bus_request_n),
        .host_chip_select_n(host_chip_select_n),
        .host_bus_grant_n(host_bus_grant_n), .host_ack(host_ack),
        .host_ready(host_ready), .link_clock(link_clock),
        .link_data(link_data), .link_ack(link_ack), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_addr(instr_addr),
        .program_counter(program_counter), .core_idle(core_idle),
        .dma_irq(dma_irq));

    bml_link_sender snd_u (.link_clock(link_clock), .link_data(link_data),
        .link_ack(link_ack));

    // Collect loaded words
    always @(posedge clock) begin
        cycles++;
        n_ack += (link_ack === 1'b1);
        if (instr_valid === 1'b1) begin
            got_q.push_back(instr_word);
            adr_q.push_back(instr_addr);
        end
        if (cycles == 20000) begin
            error_cnt++;
            close_out;
        end
    end

    task close_out;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Expected mode from the strap table
    function automatic logic [2:0] mode_enc(input logic [2:0] s);
        case (s)
            3'h0: return 3'h0;
            3'h1: return 3'h1;
            3'h3: return 3'h2;
            3'h4, 3'h5: return 3'h3;
            default: return 3'h4;
        endcase
    endfunction : mode_enc

    task reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : reg_wr

    // Read data stand one cycle only
    task reg_rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        rd = reg_rdata;
    endtask : reg_rd

    task chk_reg(input logic [3:0] a, input logic [31:0] exp);
        reg_rd(a);
        chk(48'(rd), 48'(exp));
    endtask : chk_reg

    // Long enough for the strap sync
    task boot_reset(input logic [2:0] s);
        @(posedge clock);
        {eprom_boot_select, link_boot_select, boot_memory_select} <= s;
        rst <= 1'b1;
        host_bus_request_n <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        exp_q.delete();
        got_q.delete();
        adr_q.delete();
    endtask : boot_reset

    // Three 16-bit writes, LSW first
    task host_word(input logic [47:0] v);
        for (int i = 0; i < 3; i++) begin
            reg_wr(bml_pkg::ADDR_EXT_BUF0, {16'h0, v[16 * i +: 16]});
        end
    endtask : host_word

    task host_open(input logic cs_n);
        @(posedge clock);
        host_bus_request_n <= 1'b0;
        host_chip_select_n <= cs_n;
        for (int i = 0; i < 20 && host_bus_grant_n !== 1'b0; i++) begin
            @(posedge clock);
        end
        @(negedge clock);
        chk(48'(host_bus_grant_n), 48'h0);
        chk(48'(cs_n ? host_ack : host_ready), 48'h1);
    endtask : host_open

    task chk_loads;
        repeat (4) @(posedge clock);
        chk(48'(got_q.size()), 48'(exp_q.size()));
        foreach (exp_q[i]) begin
            if (i < got_q.size()) begin
                chk(got_q[i], exp_q[i]);
                chk(48'(adr_q[i]), 48'(bml_pkg::INT_INDEX_RST + i));
            end
        end
    endtask : chk_loads

    initial begin
        void'($urandom(32'h83707EFC));
        repeat (2) @(posedge clock);
        // Host boot: resets, refused writes, full load
        boot_reset(3'h1);
        chk(48'(program_counter), 48'(bml_pkg::PC_HOST_LINK));
        chk(48'(core_idle), 48'h1);
        chk_reg(bml_pkg::ADDR_DMA_CTRL_CH10, bml_pkg::DMA_CH10_HOST_RST);
        chk_reg(bml_pkg::ADDR_INT_INDEX, bml_pkg::INT_INDEX_RST);
        chk_reg(bml_pkg::ADDR_INT_COUNT, 32'(WORDS));
        chk_reg(bml_pkg::ADDR_WAIT, bml_pkg::WAIT_RST);
        chk_reg(4'hC, 32'h0);
        host_word(48'h1111_2222_3333);
        chk(48'(got_q.size()), 48'h0);
        host_open(1'b1);
        reg_wr(bml_pkg::ADDR_SECOND_MODE, 32'h1 << bml_pkg::BUS_LOCK_BIT);
        host_word(48'h4444_5555_6666);
        chk(48'(got_q.size()), 48'h0);
        reg_wr(bml_pkg::ADDR_SECOND_MODE, 32'h0);
        for (int i = 0; i < WORDS; i++) begin
            w = {$urandom, $urandom};
            exp_q.push_back(w);
            host_word(w);
        end
        chk_loads;
        chk(48'(dma_irq), 48'h1);
        chk(48'(core_idle), 48'h0);
        reg_rd(bml_pkg::ADDR_STATUS);
        chk(48'(rd[bml_pkg::STAT_DONE_BIT]), 48'h1);
        host_word({$urandom, $urandom});
        chk_loads;
        // Second host boot, unpacked words, asynchronous transfers
        boot_reset(3'h1);
        host_open(1'b0);
        reg_wr(bml_pkg::ADDR_DMA_CTRL_CH10,
            bml_pkg::DMA_CH10_HOST_RST & ~(32'h3 << bml_pkg::DMA_PACKING_MODE_LSB));
        rd = $urandom;
        exp_q.push_back({16'h0, rd});
        reg_wr(bml_pkg::ADDR_EXT_BUF0, rd);
        chk_loads;
        // Link boot, straps moved after reset must not matter
        boot_reset(3'h3);
        {eprom_boot_select, link_boot_select} <= 2'h2;
        chk_reg(bml_pkg::ADDR_DMA_CTRL_CH6, bml_pkg::DMA_CH6_LINK_RST);
        chk_reg(bml_pkg::ADDR_DMA_CTRL_CH10, bml_pkg::DMA_CH10_LINK_RST);
        for (int i = 0; i < WORDS; i++) begin
            w = {$urandom, $urandom};
            exp_q.push_back(w);
            snd_u.send_word(w);
        end
        chk_loads;
        chk(48'(n_ack), 48'(12 * WORDS));
        chk(48'(dma_irq), 48'h1);
        reg_rd(bml_pkg::ADDR_STATUS);
        chk(48'(rd[bml_pkg::STAT_MODE_LSB +: 3]), 48'h2);
        // Every strap combination
        for (int s = 0; s < 8; s++) begin
            boot_reset(3'(s));
            reg_rd(bml_pkg::ADDR_STATUS);
            chk(48'(rd[bml_pkg::STAT_MODE_LSB +: 3]), 48'(mode_enc(3'(s))));
            if (s == 0) begin
                chk(48'(program_counter), 48'(bml_pkg::PC_NO_BOOT));
                chk_reg(bml_pkg::ADDR_DMA_CTRL_CH10,
                    bml_pkg::DMA_DEFAULT_RST);
            end
        end
        close_out;
    end
endmodule : bml_loader_bench
